// file: bench/egress_tag_and_discard_table_tb_top.sv
`timescale 1ns/100ps
module egress_tag_and_discard_table_tb_top
    import egress_tag_pkg::*;
;
    localparam logic [11:0] IN_VID = 12'h123;
    localparam logic [2:0]  IN_PRI = 3'h5;
    localparam logic [11:0] IG_VID = 12'h456;
    localparam logic [2:0]  IG_PRI = 3'h2;
    localparam logic [11:0] EG_VID = 12'h789;
    localparam logic [2:0]  EG_PRI = 3'h6;

    logic        ref_clk;
    logic        resetn;
    logic [15:0] address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        pkt_valid;
    logic [1:0]  pkt_kind;
    logic [1:0]  egress_port;
    logic        untag_default;
    logic        untag_incoming;
    logic        tag_valid;
    logic [2:0]  tag_action;
    logic [11:0] tag_vid;
    logic [2:0]  tag_prio;
    logic        yellow_valid;
    logic [7:0]  buffer_usage;
    logic        drop_valid;
    logic        drop;
    int          error_cnt;
    int          num_checks;
    logic [31:0] rd;
    int          drops;

    egress_tag_and_discard_table egress_tag_and_discard_table_inst (
        .ref_clk(ref_clk), .resetn(resetn), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pkt_valid(pkt_valid), .pkt_kind(pkt_kind),
        .egress_port(egress_port), .untag_default(untag_default),
        .untag_incoming(untag_incoming), .pkt_vid(IN_VID), .pkt_prio(IN_PRI),
        .ingress_default_vid(IG_VID), .ingress_default_prio(IG_PRI),
        .egress_default_vid(EG_VID), .egress_default_prio(EG_PRI), .tag_valid(tag_valid),
        .tag_action(tag_action), .tag_vid(tag_vid), .tag_prio(tag_prio),
        .yellow_valid(yellow_valid), .buffer_usage(buffer_usage), .drop_valid(drop_valid),
        .drop(drop)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // request held until the edge that sees waitrequest low, read data taken there
    task automatic bus(input logic rnw, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= a;
        read <= rnw;
        write <= ~rnw;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // one wait state: the answer is seen on the second edge after the request rose
        check(32'(n), 32'd2);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'hF, rd);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h0, 4'hF, rd);
        check(rd, exp);
    endtask

    task automatic entry_wr(input int i, input logic [9:0] v);
        wr(ADDR_WDATA, 32'(v));
        wr(ADDR_CMD, 32'(i) & 32'h0000000F);
    endtask

    task automatic tag_case(input logic [1:0] k, input logic [1:0] p, input logic ud,
                            input logic ui, input logic [2:0] act, input logic [11:0] v,
                            input logic [2:0] pr);
        @(posedge ref_clk);
        pkt_valid <= 1'b1;
        pkt_kind <= k;
        egress_port <= p;
        untag_default <= ud;
        untag_incoming <= ui;
        @(posedge ref_clk);
        pkt_valid <= 1'b0;
        #1;
        check(32'(tag_valid), 32'h1);
        check(32'(tag_action), 32'(act));
        // the source tag carries no documented fields here
        if (act != ACT_SOURCE_TAG) begin
            check(32'({tag_vid, tag_prio}), 32'({v, pr}));
        end
    endtask

    task automatic yellow(input logic [7:0] u);
        @(posedge ref_clk);
        yellow_valid <= 1'b1;
        buffer_usage <= u;
        @(posedge ref_clk);
        yellow_valid <= 1'b0;
        #1;
        check(32'(drop_valid), 32'h1);
        if (drop === 1'b1) begin
            drops++;
        end
    endtask

    initial begin
        #50000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        {address, read, write, byteenable, writedata} = '0;
        {pkt_valid, pkt_kind, egress_port, untag_default, untag_incoming} = '0;
        {yellow_valid, buffer_usage} = '0;
        error_cnt = 0;
        num_checks = 0;
        drops = 0;
        resetn = 1'b0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk(ADDR_WDATA, 32'h0);
        rd_chk(ADDR_RDATA, 32'h0);
        rd_chk(ADDR_TAG, 32'h0);
        rd_chk(16'h7040, 32'h0);
        wr(ADDR_WDATA, 32'hFFFFFFFF);
        rd_chk(ADDR_WDATA, 32'h000003FF);
        bus(1'b0, ADDR_WDATA, 32'h0, 4'h1, rd);
        rd_chk(ADDR_WDATA, 32'h00000300);
        for (int i = 0; i < 16; i++) entry_wr(i, 10'(i * 61 + 7));
        for (int i = 15; i >= 0; i--) begin
            wr(ADDR_CMD, 32'h10 | 32'(i));
            rd_chk(ADDR_RDATA, 32'(i * 61 + 7));
        end
        rd_chk(ADDR_CMD, 32'h00000010);
        wr(ADDR_RDATA, 32'h2AA);
        rd_chk(ADDR_RDATA, 32'h7);
        wr(ADDR_TAG, 32'hFFFFFFFF);
        rd_chk(ADDR_TAG, 32'h003F3F3F);
        wr(ADDR_TAG, 32'h003E0000);
        tag_case(PKT_UNTAGGED, 2'd2, 1'b0, 1'b0, ACT_INSERT, IG_VID, IG_PRI);
        tag_case(PKT_UNTAGGED, 2'd2, 1'b1, 1'b0, ACT_PASS, IN_VID, IN_PRI);
        tag_case(PKT_TAGGED, 2'd2, 1'b0, 1'b0, ACT_MODIFY, EG_VID, EG_PRI);
        tag_case(PKT_TAGGED, 2'd2, 1'b0, 1'b1, ACT_STRIP, IN_VID, IN_PRI);
        tag_case(PKT_PRIO_TAGGED, 2'd2, 1'b0, 1'b0, ACT_MODIFY, IG_VID, EG_PRI);
        tag_case(PKT_TAGGED, 2'd3, 1'b0, 1'b0, ACT_PASS, IN_VID, IN_PRI);
        tag_case(PKT_SPECIAL, 2'd2, 1'b0, 1'b0, ACT_STRIP, IN_VID, IN_PRI);
        wr(ADDR_TAG, 32'h001A0000);
        tag_case(PKT_TAGGED, 2'd2, 1'b0, 1'b0, ACT_PASS, IN_VID, IN_PRI);
        tag_case(PKT_PRIO_TAGGED, 2'd2, 1'b0, 1'b0, ACT_MODIFY, IG_VID, EG_PRI);
        wr(ADDR_TAG, 32'h000E0000);
        tag_case(PKT_TAGGED, 2'd2, 1'b0, 1'b0, ACT_MODIFY, IN_VID, EG_PRI);
        wr(ADDR_TAG, 32'h00060000);
        tag_case(PKT_PRIO_TAGGED, 2'd2, 1'b0, 1'b0, ACT_MODIFY, IG_VID, IN_PRI);
        tag_case(PKT_TAGGED, 2'd2, 1'b0, 1'b0, ACT_PASS, IN_VID, IN_PRI);
        wr(ADDR_TAG, 32'h003D2200);
        tag_case(PKT_UNTAGGED, 2'd1, 1'b0, 1'b0, ACT_INSERT, IG_VID, IG_PRI);
        tag_case(PKT_UNTAGGED, 2'd2, 1'b0, 1'b0, ACT_PASS, IN_VID, IN_PRI);
        tag_case(PKT_TAGGED, 2'd2, 1'b0, 1'b0, ACT_STRIP, IN_VID, IN_PRI);
        wr(ADDR_TAG, 32'h003C003F);
        tag_case(PKT_TAGGED, 2'd2, 1'b0, 1'b0, ACT_PASS, IN_VID, IN_PRI);
        tag_case(PKT_SPECIAL, 2'd2, 1'b0, 1'b0, ACT_STRIP, IN_VID, IN_PRI);
        tag_case(PKT_UNTAGGED, 2'd0, 1'b0, 1'b0, ACT_SOURCE_TAG, IN_VID, IN_PRI);
        // only the 80..95 range may discard; the others hold zero
        for (int i = 0; i < 16; i++) entry_wr(i, (i == 9) ? 10'h3FF : 10'h000);
        for (int i = 0; i < 10; i++) yellow(8'd79);
        for (int i = 0; i < 10; i++) yellow(8'd96);
        check(32'(drops), 32'h0);
        for (int i = 0; i < 10; i++) yellow(8'd80);
        for (int i = 0; i < 10; i++) yellow(8'd95);
        check(32'(drops >= 19), 32'h1);
        report_and_stop();
    end
endmodule

// file: design/egress_tag_and_discard_table.sv
`timescale 1ns/100ps
module egress_tag_and_discard_table
    import egress_tag_pkg::*;
#(
    parameter int PROB_WIDTH = PROB_W,
    parameter int ENTRIES    = ENTRY_COUNT
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        pkt_valid,
    input  wire logic [1:0]  pkt_kind,
    input  wire logic [1:0]  egress_port,
    input  wire logic        untag_default,
    input  wire logic        untag_incoming,
    input  wire logic [11:0] pkt_vid,
    input  wire logic [2:0]  pkt_prio,
    input  wire logic [11:0] ingress_default_vid,
    input  wire logic [2:0]  ingress_default_prio,
    input  wire logic [11:0] egress_default_vid,
    input  wire logic [2:0]  egress_default_prio,
    output logic             tag_valid,
    output logic      [2:0]  tag_action,
    output logic      [11:0] tag_vid,
    output logic      [2:0]  tag_prio,
    input  wire logic        yellow_valid,
    input  wire logic [7:0]  buffer_usage,
    output logic             drop_valid,
    output logic             drop
);
    if (PROB_WIDTH != 10) begin
        $error("weight width must be 10");
    end
    if (ENTRIES != 16) begin
        $error("weight table must have 16 entries");
    end

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
        logic [9:0]  write_data;
        logic [9:0]  read_data;
        logic        cmd_rnw;
        logic [3:0]  cmd_index;
        logic [21:0] tag_ctrl;
        logic        tag_valid;
        tag_action_t tag_action;
        logic [11:0] tag_vid;
        logic [2:0]  tag_prio;
    } bank_state_t;

    bank_state_t st;
    bank_state_t next_st;

    logic [9:0]  weight_table [ENTRIES];
    logic [3:0]  range_index;
    logic [9:0]  range_entry;
    logic        accept;
    logic        cmd_hit;
    logic [31:0] cmd_word;
    logic [5:0]  pc;
    port_type_t  ptype;

    // one wait state: each access is answered on the edge after it is seen
    assign accept   = (read || write) && st.waitrequest;
    assign cmd_hit  = accept && write && (address == ADDR_CMD);
    assign cmd_word = merge_bytes({27'h0, st.cmd_rnw, st.cmd_index}, writedata, byteenable);

    // no reset on purpose: software must load every entry first
    always_ff @(posedge ref_clk) begin
        if (cmd_hit && !cmd_word[CMD_RNW_BIT]) begin
            weight_table[cmd_word[CMD_INDEX_LSB +: INDEX_W]] <= st.write_data;
        end
    end

    assign range_entry = weight_table[range_index];

    always_comb begin
        case (egress_port)
            2'd0: pc = st.tag_ctrl[0*PORT_STRIDE +: PORT_FIELD_W];
            2'd1: pc = st.tag_ctrl[1*PORT_STRIDE +: PORT_FIELD_W];
            2'd2: pc = st.tag_ctrl[2*PORT_STRIDE +: PORT_FIELD_W];
            default: pc = 6'h00;
        endcase
        ptype = port_type_t'(pc[TYPE_LSB +: 2]);
    end

    always_comb begin
        logic [31:0] wv;
        wv = 32'h0;
        next_st = st;
        next_st.waitrequest = 1'b1;
        if (accept) begin
            next_st.waitrequest = 1'b0;
            if (read) begin
                case (address)
                    ADDR_CMD:   next_st.readdata = {27'h0, st.cmd_rnw, st.cmd_index};
                    ADDR_WDATA: next_st.readdata = {22'h0, st.write_data};
                    ADDR_RDATA: next_st.readdata = {22'h0, st.read_data};
                    ADDR_TAG:   next_st.readdata = {10'h0, st.tag_ctrl};
                    default:    next_st.readdata = 32'h0;
                endcase
            end else begin
                case (address)
                    ADDR_CMD: begin
                        next_st.cmd_rnw   = cmd_word[CMD_RNW_BIT];
                        next_st.cmd_index = cmd_word[CMD_INDEX_LSB +: INDEX_W];
                        if (cmd_word[CMD_RNW_BIT]) begin
                            next_st.read_data = weight_table[cmd_word[3:0]];
                        end
                    end
                    ADDR_WDATA: begin
                        wv = merge_bytes({22'h0, st.write_data}, writedata, byteenable);
                        next_st.write_data = wv[9:0];
                    end
                    ADDR_TAG: begin
                        wv = merge_bytes({10'h0, st.tag_ctrl}, writedata, byteenable);
                        next_st.tag_ctrl = wv[21:0] & TAG_CTRL_MASK;
                    end
                    default: begin
                        next_st.tag_ctrl = st.tag_ctrl;
                    end
                endcase
            end
        end

        next_st.tag_valid  = pkt_valid;
        next_st.tag_action = ACT_PASS;
        next_st.tag_vid    = pkt_vid;
        next_st.tag_prio   = pkt_prio;
        case (ptype)
            PTYPE_DUMB: begin
                if (pkt_kind == PKT_SPECIAL) begin
                    next_st.tag_action = ACT_STRIP;
                end
            end
            PTYPE_ACCESS: begin
                if (pkt_kind != PKT_UNTAGGED) begin
                    next_st.tag_action = ACT_STRIP;
                end
            end
            PTYPE_HYBRID: begin
                case (pkt_kind)
                    PKT_UNTAGGED: begin
                        if (pc[INSERT_BIT] && !untag_default) begin
                            next_st.tag_action = ACT_INSERT;
                            next_st.tag_vid    = ingress_default_vid;
                            next_st.tag_prio   = ingress_default_prio;
                        end
                    end
                    PKT_PRIO_TAGGED: begin
                        if (untag_incoming) begin
                            next_st.tag_action = ACT_STRIP;
                        end else begin
                            next_st.tag_action = ACT_MODIFY;
                            next_st.tag_vid    = ingress_default_vid;
                            if (pc[CHG_PRIO_BIT]) begin
                                next_st.tag_prio = egress_default_prio;
                            end
                        end
                    end
                    PKT_TAGGED: begin
                        if (untag_incoming) begin
                            next_st.tag_action = ACT_STRIP;
                        end else if (pc[CHG_TAG_BIT]) begin
                            if (pc[CHG_VID_BIT] || pc[CHG_PRIO_BIT]) begin
                                next_st.tag_action = ACT_MODIFY;
                            end
                            if (pc[CHG_VID_BIT]) begin
                                next_st.tag_vid = egress_default_vid;
                            end
                            if (pc[CHG_PRIO_BIT]) begin
                                next_st.tag_prio = egress_default_prio;
                            end
                        end
                    end
                    default: begin
                        next_st.tag_action = ACT_STRIP;
                    end
                endcase
            end
            PTYPE_CPU: begin
                next_st.tag_action = ACT_SOURCE_TAG;
            end
            default: begin
                next_st.tag_action = ACT_PASS;
            end
        endcase
        if (egress_port == 2'd3) begin
            next_st.tag_action = ACT_PASS;
            next_st.tag_vid    = pkt_vid;
            next_st.tag_prio   = pkt_prio;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st.waitrequest <= 1'b1;
            st.readdata    <= 32'h0;
            st.write_data  <= WDATA_RESET;
            st.read_data   <= RDATA_RESET;
            st.cmd_rnw     <= 1'b0;
            st.cmd_index   <= 4'h0;
            st.tag_ctrl    <= TAG_CTRL_RESET;
            st.tag_valid   <= 1'b0;
            st.tag_action  <= ACT_PASS;
            st.tag_vid     <= 12'h000;
            st.tag_prio    <= 3'h0;
        end else begin
            st <= next_st;
        end
    end

    yellow_discard #(
        .PROB_WIDTH (PROB_WIDTH)
    ) yellow_discard_inst (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .yellow_valid (yellow_valid),
        .buffer_usage (buffer_usage),
        .entry        (range_entry),
        .range_index  (range_index),
        .drop_valid   (drop_valid),
        .drop         (drop)
    );

    assign readdata    = st.readdata;
    assign waitrequest = st.waitrequest;
    assign tag_valid   = st.tag_valid;
    assign tag_action  = st.tag_action;
    assign tag_vid     = st.tag_vid;
    assign tag_prio    = st.tag_prio;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic hyb;
    assign hyb = (ptype == PTYPE_HYBRID) && (egress_port != 2'd3);

    sequence table_read_cmd_s;
        cmd_hit && cmd_word[CMD_RNW_BIT];
    endsequence
    sequence table_write_cmd_s;
        cmd_hit && !cmd_word[CMD_RNW_BIT];
    endsequence

    answer_one_wait_a: assert property ((read || write) && waitrequest
            |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not exactly one cycle after request");
    wdata_store_a: assert property (accept && write && address == ADDR_WDATA
            && byteenable == 4'hF |=> st.write_data == $past(writedata[9:0]))
        else $error("write-data register did not take the written value");
    table_read_a: assert property (table_read_cmd_s |=>
            st.read_data == weight_table[$past(cmd_word[3:0])])
        else $error("read-data does not show the fetched entry");
    table_write_a: assert property (table_write_cmd_s |=>
            weight_table[$past(cmd_word[3:0])] == $past(st.write_data))
        else $error("table entry not loaded from write-data");
    insert_tag_a: assert property (pkt_valid && hyb && pkt_kind == PKT_UNTAGGED
            && pc[INSERT_BIT] && !untag_default |=> tag_action == ACT_INSERT
            && tag_vid == $past(ingress_default_vid))
        else $error("untagged packet was not given the ingress default tag");
    insert_blocked_a: assert property (pkt_valid && pkt_kind == PKT_UNTAGGED
            && (untag_default || !hyb) |=> tag_action != ACT_INSERT)
        else $error("tag inserted though blocked");
    strip_untag_a: assert property (pkt_valid && hyb && untag_incoming
            && pkt_kind == PKT_TAGGED |=> tag_action == ACT_STRIP)
        else $error("tag kept though un-tag bit set");
    prio_tag_vid_a: assert property (pkt_valid && hyb && pkt_kind == PKT_PRIO_TAGGED
            && !untag_incoming |=> tag_vid == $past(ingress_default_vid))
        else $error("priority tag VID not replaced by ingress default");
    change_gate_a: assert property (pkt_valid && hyb && pkt_kind == PKT_TAGGED
            && !untag_incoming && !pc[CHG_TAG_BIT] |=> tag_action == ACT_PASS
            && tag_vid == $past(pkt_vid) && tag_prio == $past(pkt_prio))
        else $error("tagged packet changed without change-tag");
    change_vid_a: assert property (pkt_valid && hyb && pkt_kind == PKT_TAGGED
            && !untag_incoming && pc[CHG_TAG_BIT] && pc[CHG_VID_BIT]
            |=> tag_vid == $past(egress_default_vid))
        else $error("tagged VID not replaced by egress default");
    change_prio_a: assert property (pkt_valid && hyb && pkt_kind == PKT_TAGGED
            && !untag_incoming && pc[CHG_TAG_BIT] && pc[CHG_PRIO_BIT]
            |=> tag_prio == $past(egress_default_prio))
        else $error("tagged priority not replaced by egress default");
    // the four tagging bits must be inert unless the port is hybrid
    hybrid_only_a: assert property (pkt_valid && !hyb
            |=> tag_action != ACT_INSERT && tag_action != ACT_MODIFY)
        else $error("tag added or changed on a port that is not hybrid");
endmodule

// file: design/egress_tag_pkg.sv
package egress_tag_pkg;

    localparam int PROB_W      = 10;
    localparam int ENTRY_COUNT = 16;
    localparam int INDEX_W     = 4;

    // register indices; the byte address on the bus is four times the index
    localparam logic [15:0] IDX_CMD   = 16'h1C09;
    localparam logic [15:0] IDX_WDATA = 16'h1C0A;
    localparam logic [15:0] IDX_RDATA = 16'h1C0B;
    localparam logic [15:0] IDX_TAG   = 16'h1C0C;
    localparam logic [15:0] ADDR_CMD   = {IDX_CMD[13:0], 2'b00};
    localparam logic [15:0] ADDR_WDATA = {IDX_WDATA[13:0], 2'b00};
    localparam logic [15:0] ADDR_RDATA = {IDX_RDATA[13:0], 2'b00};
    localparam logic [15:0] ADDR_TAG   = {IDX_TAG[13:0], 2'b00};

    localparam int CMD_RNW_BIT   = 4;
    localparam int CMD_INDEX_LSB = 0;

    localparam logic [9:0]  WDATA_RESET    = 10'h000;
    localparam logic [9:0]  RDATA_RESET    = 10'h000;
    localparam logic [21:0] TAG_CTRL_RESET = 22'h000000;
    localparam logic [21:0] TAG_CTRL_MASK  = 22'h3F3F3F;

    // per-port field layout inside the tagging control word
    localparam int PORT_STRIDE  = 8;
    localparam int PORT_FIELD_W = 6;
    localparam int TYPE_LSB     = 0;
    localparam int CHG_TAG_BIT  = 2;
    localparam int CHG_PRIO_BIT = 3;
    localparam int CHG_VID_BIT  = 4;
    localparam int INSERT_BIT   = 5;

    localparam logic [9:0] LFSR_SEED = 10'h001;

    typedef enum logic [1:0] {
        PTYPE_DUMB   = 2'b00,
        PTYPE_ACCESS = 2'b01,
        PTYPE_HYBRID = 2'b10,
        PTYPE_CPU    = 2'b11
    } port_type_t;

    typedef enum logic [1:0] {
        PKT_UNTAGGED    = 2'b00,
        PKT_PRIO_TAGGED = 2'b01,
        PKT_TAGGED      = 2'b10,
        PKT_SPECIAL     = 2'b11
    } pkt_kind_t;

    typedef enum logic [2:0] {
        ACT_PASS       = 3'h0,
        ACT_INSERT     = 3'h1,
        ACT_STRIP      = 3'h2,
        ACT_MODIFY     = 3'h3,
        ACT_SOURCE_TAG = 3'h4
    } tag_action_t;

    // finer ranges at the low end of buffer usage
    function automatic logic [3:0] usage_range(input logic [7:0] u);
        if (u < 8'h40) begin
            return {1'b0, u[5:3]};
        end else if (u < 8'h80) begin
            return {2'b10, u[5:4]};
        end
        return {2'b11, u[6:5]};
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// file: design/yellow_discard.sv
`timescale 1ns/100ps
module yellow_discard
    import egress_tag_pkg::*;
#(
    parameter int PROB_WIDTH = PROB_W
) (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  yellow_valid,
    input  wire logic [7:0]            buffer_usage,
    input  wire logic [PROB_WIDTH-1:0] entry,
    output logic      [INDEX_W-1:0]    range_index,
    output logic                       drop_valid,
    output logic                       drop
);
    if (PROB_WIDTH != 10) begin
        $error("yellow_discard serves 10-bit weights only");
    end

    typedef struct packed {
        logic [9:0] lfsr;
        logic       drop_valid;
        logic       drop;
    } disc_state_t;

    disc_state_t st;
    disc_state_t next_st;

    assign range_index = usage_range(buffer_usage);

    always_comb begin
        next_st = st;
        // free-running, so each packet sees a fresh draw; never reaches zero
        next_st.lfsr = {st.lfsr[8:0], st.lfsr[9] ^ st.lfsr[6]};
        next_st.drop_valid = yellow_valid;
        next_st.drop = yellow_valid && (st.lfsr < entry);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '{lfsr: LFSR_SEED, drop_valid: 1'b0, drop: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign drop_valid = st.drop_valid;
    assign drop       = st.drop;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    zero_never_drops_a: assert property (yellow_valid && entry == 10'h000
            |=> drop_valid && !drop)
        else $error("zero weight caused a discard");
    drop_needs_yellow_a: assert property (drop |-> drop_valid && $past(yellow_valid))
        else $error("discard without a yellow packet");
endmodule
